// file: tws_cfg.svh
// Constants of the two-wire serial register block
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// Register indices on the register port
`define TWS_IDX_BRG 3'h0
`define TWS_IDX_STAT 3'h1
`define TWS_IDX_OWN 3'h2
`define TWS_IDX_DATA 3'h3
`define TWS_IDX_CTRL 3'h4

// Control bit positions
`define TWS_C_DONE 7
`define TWS_C_ACK 6
`define TWS_C_STA 5
`define TWS_C_STO 4
`define TWS_C_WC 3
`define TWS_C_EN 2
`define TWS_C_IE 0

// Reset values
`define TWS_RST_BRG 8'h00
`define TWS_RST_DATA 8'hff
`define TWS_RST_OWN 8'hfe
`define TWS_RST_PS 2'h0

// Quarter of the fixed 32-cycle part of the serial clock period
`define TWS_HALF_BASE 15'h0008

// Status codes
`define TWS_S_NOINFO 5'h1f
`define TWS_S_START 5'h01
`define TWS_S_RSTART 5'h02
`define TWS_S_ADDR_ACK 5'h03
`define TWS_S_ADDR_NAK 5'h04
`define TWS_S_DATA_ACK 5'h05
`define TWS_S_DATA_NAK 5'h06
`define TWS_S_ARB_LOST 5'h07
`define TWS_S_RXD_ACK 5'h08
`define TWS_S_RXD_NAK 5'h09
`define TWS_S_SLA_OWN 5'h0a
`define TWS_S_SLA_GC 5'h0b
`define TWS_S_SLA_RD 5'h0c
`define TWS_S_SDATA 5'h0d
`define TWS_S_SSTOP 5'h0e

`endif

// file: tws_pkg.sv
// Types of the two-wire serial register block
package tws_pkg;

    typedef enum logic [2:0] {
        TWS_IDLE,
        TWS_MSTART,
        TWS_MHOLD,
        TWS_MBIT,
        TWS_MSTOP,
        TWS_SBIT
    } tws_fsm_t;

    typedef struct packed {
        tws_fsm_t state;
        logic [1:0] q;
        logic [3:0] bitc;
        logic [14:0] tick;
        logic [7:0] brg;
        logic [1:0] ps;
        logic [7:0] own;
        logic [7:0] shd;
        logic done;
        logic ack_en;
        logic sta;
        logic sto;
        logic wc;
        logic en;
        logic ie;
        logic [4:0] stat;
        logic [4:0] pend;
        logic busy;
        logic rep;
        logic mrx;
        logic stx;
        logic arb;
        logic addr_ph;
        logic ackb;
        logic scl_dr;
        logic sda_dr;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic scl_oe;
        logic sda_oe;
        logic irq;
        logic [7:0] rdata;
    } tws_state_t;

endpackage : tws_pkg

// file: tws_regs.sv
// Two-wire serial unit: registers, bit rate generator, master and slave engine
`timescale 1ns/1ps
`default_nettype none
`include "tws_cfg.svh"

module tws_regs
    import tws_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic global_irq_enable,
    output logic irq,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);

    localparam tws_state_t RST = '{state: TWS_IDLE, brg: `TWS_RST_BRG, ps: `TWS_RST_PS,
        own: `TWS_RST_OWN, shd: `TWS_RST_DATA, stat: `TWS_S_NOINFO, pend: `TWS_S_NOINFO,
        scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
        default: '0};

    tws_state_t st_r;
    tws_state_t st_nxt;
    logic [14:0] half;
    logic tk;
    logic srise;
    logic sfall;
    logic sta_d;
    logic sto_d;
    logic match;
    logic dbit;

    // ---------------------------------------------------------------
    // Bus events
    // ---------------------------------------------------------------
    assign half = `TWS_HALF_BASE + (15'(st_r.brg) << {st_r.ps, 1'b0});
    assign srise = st_r.scl_s & ~st_r.scl_p;
    assign sfall = ~st_r.scl_s & st_r.scl_p;
    assign sta_d = st_r.scl_s & st_r.scl_p & st_r.sda_p & ~st_r.sda_s;
    assign sto_d = st_r.scl_s & st_r.scl_p & ~st_r.sda_p & st_r.sda_s;
    assign match = st_r.ack_en & ((st_r.shd[7:1] == st_r.own[7:1])
        | (st_r.own[0] & (st_r.shd[7:1] == 7'h00)));
    // Bit to put on the line, 1 meaning released
    assign dbit = (st_r.bitc < 4'h8) ? (st_r.mrx | st_r.shd[7]) : (~st_r.mrx | ~st_r.ack_en);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        tk = 1'b0;
        st_nxt.scl_m = scl_i;
        st_nxt.scl_s = st_r.scl_m;
        st_nxt.scl_p = st_r.scl_s;
        st_nxt.sda_m = sda_i;
        st_nxt.sda_s = st_r.sda_m;
        st_nxt.sda_p = st_r.sda_s;
        st_nxt.stat = st_r.done ? st_r.pend : `TWS_S_NOINFO;

        if (wr_en) begin
            case (addr)
                `TWS_IDX_BRG: st_nxt.brg = wdata;
                `TWS_IDX_STAT: st_nxt.ps = wdata[1:0];
                `TWS_IDX_OWN: st_nxt.own = wdata;
                `TWS_IDX_DATA: begin
                    if (st_r.done) begin
                        st_nxt.shd = wdata;
                        st_nxt.wc = 1'b0;
                    end else begin
                        st_nxt.wc = 1'b1;
                    end
                end
                `TWS_IDX_CTRL: begin
                    st_nxt.ack_en = wdata[`TWS_C_ACK];
                    st_nxt.sta = wdata[`TWS_C_STA];
                    st_nxt.sto = wdata[`TWS_C_STO];
                    st_nxt.en = wdata[`TWS_C_EN];
                    st_nxt.ie = wdata[`TWS_C_IE];
                    if (wdata[`TWS_C_DONE]) begin
                        st_nxt.done = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Clock stretching by other parties restarts the quarter-period count from zero
        if (st_r.state == TWS_MSTART || st_r.state == TWS_MBIT || st_r.state == TWS_MSTOP) begin
            if (!st_r.scl_dr && !st_r.scl_s) begin
                st_nxt.tick = '0;
            end else if (st_r.tick >= half - 15'h0001) begin
                st_nxt.tick = '0;
                tk = 1'b1;
            end else begin
                st_nxt.tick = st_r.tick + 15'h0001;
            end
        end

        if (!st_r.en) begin
            st_nxt.state = TWS_IDLE;
            st_nxt.scl_dr = 1'b0;
            st_nxt.sda_dr = 1'b0;
            st_nxt.busy = 1'b0;
        end else begin
            if (sta_d) begin
                st_nxt.busy = 1'b1;
            end
            if (sto_d) begin
                st_nxt.busy = 1'b0;
            end
            case (st_r.state)
                TWS_IDLE: begin
                    st_nxt.scl_dr = 1'b0;
                    st_nxt.sda_dr = 1'b0;
                    if (st_r.sto && !st_r.done) begin
                        st_nxt.sto = 1'b0;
                    end else if (sta_d) begin
                        st_nxt.state = TWS_SBIT;
                        st_nxt.bitc = '0;
                        st_nxt.addr_ph = 1'b1;
                        st_nxt.stx = 1'b0;
                        st_nxt.arb = 1'b0;
                    end else if (st_r.sta && !st_r.done && !st_r.busy) begin
                        st_nxt.state = TWS_MSTART;
                        st_nxt.q = '0;
                        st_nxt.tick = '0;
                        st_nxt.rep = 1'b0;
                    end
                end
                TWS_MSTART: begin
                    if (tk) begin
                        st_nxt.q = st_r.q + 2'h1;
                        case (st_r.q)
                            2'h0: st_nxt.sda_dr = 1'b0;
                            2'h1: st_nxt.scl_dr = 1'b0;
                            2'h2: st_nxt.sda_dr = 1'b1;
                            default: begin
                                st_nxt.scl_dr = 1'b1;
                                st_nxt.done = 1'b1;
                                st_nxt.pend = st_r.rep ? `TWS_S_RSTART : `TWS_S_START;
                                st_nxt.state = TWS_MHOLD;
                                st_nxt.addr_ph = 1'b1;
                                st_nxt.mrx = 1'b0;
                            end
                        endcase
                    end
                end
                TWS_MHOLD: begin
                    // Own clock stays low here; software acts before the flag clears
                    if (!st_r.done) begin
                        st_nxt.q = '0;
                        st_nxt.tick = '0;
                        if (st_r.sta) begin
                            st_nxt.state = TWS_MSTART;
                            st_nxt.rep = 1'b1;
                        end else if (st_r.sto) begin
                            st_nxt.state = TWS_MSTOP;
                        end else begin
                            st_nxt.state = TWS_MBIT;
                            st_nxt.bitc = '0;
                        end
                    end
                end
                TWS_MBIT: begin
                    if (tk) begin
                        st_nxt.q = st_r.q + 2'h1;
                        case (st_r.q)
                            2'h0: st_nxt.sda_dr = ~dbit;
                            2'h1: st_nxt.scl_dr = 1'b0;
                            2'h2: begin
                                if (st_r.bitc < 4'h8) begin
                                    st_nxt.shd = {st_r.shd[6:0], st_r.sda_s};
                                    st_nxt.bitc = st_r.bitc + 4'h1;
                                    if (dbit && !st_r.sda_s && !st_r.mrx) begin
                                        // Lost: go on as slave with the same byte
                                        st_nxt.state = TWS_SBIT;
                                        st_nxt.sda_dr = 1'b0;
                                        st_nxt.arb = 1'b1;
                                        st_nxt.stx = 1'b0;
                                    end
                                end else begin
                                    st_nxt.ackb = ~st_r.sda_s;
                                end
                            end
                            default: begin
                                st_nxt.scl_dr = 1'b1;
                                if (st_r.bitc > 4'h8) begin
                                    st_nxt.done = 1'b1;
                                    st_nxt.state = TWS_MHOLD;
                                    st_nxt.addr_ph = 1'b0;
                                    if (st_r.addr_ph) begin
                                        st_nxt.mrx = st_r.shd[0];
                                        st_nxt.pend = st_r.ackb ? `TWS_S_ADDR_ACK : `TWS_S_ADDR_NAK;
                                    end else if (st_r.mrx) begin
                                        st_nxt.pend = st_r.ack_en ? `TWS_S_RXD_ACK : `TWS_S_RXD_NAK;
                                    end else begin
                                        st_nxt.pend = st_r.ackb ? `TWS_S_DATA_ACK : `TWS_S_DATA_NAK;
                                    end
                                end else if (st_r.bitc == 4'h8) begin
                                    st_nxt.bitc = 4'h9;
                                end
                            end
                        endcase
                    end
                end
                TWS_MSTOP: begin
                    if (tk) begin
                        st_nxt.q = st_r.q + 2'h1;
                        case (st_r.q)
                            2'h0: st_nxt.sda_dr = 1'b1;
                            2'h1: st_nxt.scl_dr = 1'b0;
                            2'h2: st_nxt.sda_dr = 1'b0;
                            default: begin
                                st_nxt.sto = 1'b0;
                                st_nxt.state = TWS_IDLE;
                            end
                        endcase
                    end
                end
                TWS_SBIT: begin
                    st_nxt.scl_dr = 1'b0;
                    if (st_r.sto && !st_r.done) begin
                        st_nxt.sto = 1'b0;
                        st_nxt.sda_dr = 1'b0;
                        st_nxt.state = TWS_IDLE;
                    end else if (sto_d) begin
                        st_nxt.sda_dr = 1'b0;
                        st_nxt.state = TWS_IDLE;
                        if (!st_r.addr_ph) begin
                            st_nxt.done = 1'b1;
                            st_nxt.pend = `TWS_S_SSTOP;
                        end
                    end else if (sta_d) begin
                        st_nxt.bitc = '0;
                        st_nxt.addr_ph = 1'b1;
                        st_nxt.stx = 1'b0;
                        st_nxt.sda_dr = 1'b0;
                    end else if (srise && st_r.bitc < 4'h8) begin
                        st_nxt.shd = {st_r.shd[6:0], st_r.sda_s};
                        st_nxt.bitc = st_r.bitc + 4'h1;
                    end else if (sfall && st_r.bitc == 4'h8) begin
                        st_nxt.bitc = 4'h9;
                        st_nxt.sda_dr = 1'b0;
                        if (st_r.addr_ph) begin
                            if (match) begin
                                st_nxt.sda_dr = 1'b1;
                                st_nxt.done = 1'b1;
                                st_nxt.addr_ph = 1'b0;
                                st_nxt.stx = st_r.shd[0];
                                st_nxt.pend = st_r.shd[0] ? `TWS_S_SLA_RD :
                                    (st_r.shd[7:1] == 7'h00) ? `TWS_S_SLA_GC : `TWS_S_SLA_OWN;
                            end else begin
                                st_nxt.state = TWS_IDLE;
                                if (st_r.arb) begin
                                    st_nxt.done = 1'b1;
                                    st_nxt.pend = `TWS_S_ARB_LOST;
                                end
                            end
                        end else if (!st_r.stx) begin
                            st_nxt.sda_dr = st_r.ack_en;
                            st_nxt.done = 1'b1;
                            st_nxt.pend = `TWS_S_SDATA;
                        end
                    end else if (sfall && st_r.bitc == 4'h9) begin
                        st_nxt.bitc = '0;
                        st_nxt.sda_dr = st_r.stx & ~st_r.shd[7];
                    end else if (sfall && st_r.stx && !st_r.addr_ph && st_r.bitc != 4'h0) begin
                        st_nxt.sda_dr = ~st_r.shd[7];
                    end
                end
                default: st_nxt.state = TWS_IDLE;
            endcase
        end

        // Pins only pulled while enabled; the flag stretches the low phase
        st_nxt.scl_oe = st_nxt.en & (st_nxt.scl_dr
            | (st_nxt.done & (st_nxt.state != TWS_IDLE)));
        st_nxt.sda_oe = st_nxt.en & st_nxt.sda_dr;
        st_nxt.irq = st_nxt.done & st_nxt.ie & global_irq_enable;

        if (rd_en) begin
            case (addr)
                `TWS_IDX_BRG: st_nxt.rdata = st_r.brg;
                `TWS_IDX_STAT: st_nxt.rdata = {st_r.stat, 1'b0, st_r.ps};
                `TWS_IDX_OWN: st_nxt.rdata = st_r.own;
                `TWS_IDX_DATA: st_nxt.rdata = st_r.shd;
                `TWS_IDX_CTRL: st_nxt.rdata = {st_r.done, st_r.ack_en, st_r.sta, st_r.sto,
                    st_r.wc, st_r.en, 1'b0, st_r.ie};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign irq = st_r.irq;
    assign scl_oe = st_r.scl_oe;
    assign sda_oe = st_r.sda_oe;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_status_delay: assert property ($rose(st_r.done) |-> st_r.stat == `TWS_S_NOINFO ##1
        st_r.stat == $past(st_r.pend)) else $error("status code not one cycle after flag");
    a_irq_gate: assert property (irq |-> st_r.done && st_r.ie)
        else $error("interrupt without flag and enable");
    a_irq_level: assert property (st_r.done && st_r.ie && global_irq_enable |=>
        irq || !st_r.done || !st_r.ie) else $error("interrupt missing");
    a_wc_set: assert property (wr_en && addr == `TWS_IDX_DATA && !st_r.done |=>
        st_r.wc && $stable(st_r.shd)) else $error("collision not flagged");
    a_wc_clear: assert property (wr_en && addr == `TWS_IDX_DATA && st_r.done |=>
        !st_r.wc && st_r.shd == $past(wdata)) else $error("data write not taken");
    // A control write in the same cycle may clear the flag or the enable
    a_scl_stretch: assert property (st_r.done && st_r.en && st_r.state != TWS_IDLE && !wr_en |=>
        scl_oe) else $error("clock not stretched");
    a_off_release: assert property (!st_r.en |=> !scl_oe && !sda_oe)
        else $error("pins driven while disabled");
    a_flag_clear: assert property (wr_en && addr == `TWS_IDX_CTRL && wdata[`TWS_C_DONE]
        && st_r.state == TWS_MHOLD |=> !st_r.done) else $error("flag not cleared");
    a_rsvd_zero: assert property (rd_en && addr == `TWS_IDX_CTRL |=> !rdata[1])
        else $error("reserved control bit read as one");
    a_rsvd_stat: assert property (rd_en && addr == `TWS_IDX_STAT |=> !rdata[2])
        else $error("reserved status bit read as one");
    a_stop_clear: assert property (st_r.state == TWS_MSTOP && st_nxt.state == TWS_IDLE
        |=> !st_r.sto) else $error("stop request not cleared");

    c_done: cover property ($rose(st_r.done));
    c_stop: cover property (st_r.state == TWS_MSTOP ##1 st_r.state == TWS_IDLE);
    c_arb: cover property (st_r.state == TWS_MBIT ##1 st_r.state == TWS_SBIT);
    c_slave: cover property (st_r.pend == `TWS_S_SLA_OWN && st_r.done);

endmodule : tws_regs
`default_nettype wire

// file: tws_slave_model.sv
// Bus slave model that acknowledges its own address and nothing else
`timescale 1ns/1ps
`default_nettype none

module tws_slave_model #(
    parameter logic [6:0] SLAVE_ADDR = 7'h50
) (
    input wire logic scl,
    input wire logic sda,
    output var logic sda_oe
);
    logic [3:0] cnt = 4'h0;
    logic [7:0] sh = 8'h00;
    logic act = 1'b0;

    initial sda_oe = 1'b0;
    // ---------------------------------------------------------------
    // Framing on the resolved wires
    // ---------------------------------------------------------------
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        cnt = 4'hf;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) if (act && cnt < 4'h8) sh = {sh[6:0], sda};
    // Only the address byte is answered; later bytes see no acknowledge
    always @(negedge scl) if (act) begin
        if (cnt == 4'h8) begin
            sda_oe = 1'b0;
            act = 1'b0;
        end else begin
            cnt = cnt + 4'h1;
            if (cnt == 4'h8 && sh[7:1] == SLAVE_ADDR) sda_oe = 1'b1;
        end
    end
endmodule : tws_slave_model

`default_nettype wire

// file: tb_tws_regs.sv
// Self-checking testbench of the two-wire serial register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end

module tb_tws_regs;
    logic clk, rst_n, wr_en, rd_en, gie, irq, scl_o, scl_oe, sda_o, sda_oe, slv_oe;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, v;
    wire logic scl_w, sda_w;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] rst_tab [6] = '{8'h00, 8'hf8, 8'hfe, 8'hff, 8'h00, 8'h00};

    // Pull-ups on both lines; the slave model never stretches the clock
    assign scl_w = ~scl_oe;
    assign sda_w = ~(sda_oe | slv_oe);

    tws_regs i_tws_regs (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .global_irq_enable(gie),
        .irq(irq), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe));
    tws_slave_model i_tws_slave_model (.scl(scl_w), .sda(sda_w), .sda_oe(slv_oe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // Register port tasks
    // ---------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // Polls one register bit under a bounded count
    task automatic wait_bit(input logic [2:0] a, input int b, input logic val);
        int n;
        n = 0;
        rd(a, v);
        while (v[b] !== val && n < 3000) begin
            rd(a, v);
            n++;
        end
        `CHK(v[b], val)
    endtask : wait_bit

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_vals();
        for (int i = 0; i < 6; i++) begin
            rd(i[2:0], v);
            `CHK(v, rst_tab[i])
        end
    endtask : t_reset_vals
    task automatic t_regs();
        wr(0, 8'h0a);
        rd(0, v);
        `CHK(v, 8'h0a)
        wr(0, 8'h00);
        wr(1, 8'hff);
        rd(1, v);
        `CHK(v, 8'hfb)
        wr(1, 8'h00);
        wr(4, 8'h42);
        rd(4, v);
        `CHK(v, 8'h40)
        wr(4, 8'h00);
        wr(3, 8'h55);
        rd(4, v);
        `CHK(v, 8'h08)
        rd(3, v);
        `CHK(v, 8'hff)
    endtask : t_regs
    task automatic t_master();
        wr(4, 8'ha5);
        wait_bit(4, 7, 1'b1);
        rd(1, v);
        `CHK(v, 8'h08)
        `CHK(irq, 1'b1)
        repeat (40) @(posedge clk);
        `CHK(scl_w, 1'b0)
        rd(4, v);
        `CHK(v, 8'had)
        wr(3, 8'ha0);
        rd(4, v);
        `CHK(v, 8'ha5)
        wr(4, 8'h85);
        wait_bit(4, 7, 1'b1);
        rd(1, v);
        `CHK(v, 8'h18)
        rd(3, v);
        `CHK(v, 8'ha0)
        wr(3, 8'h3c);
        wr(4, 8'h85);
        wait_bit(4, 7, 1'b1);
        rd(1, v);
        `CHK(v, 8'h30)
        rd(3, v);
        `CHK(v, 8'h3c)
        gie <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(4, 8'h95);
        wait_bit(4, 4, 1'b0);
        rd(4, v);
        `CHK(v, 8'h05)
        rd(1, v);
        `CHK(v, 8'hf8)
        `CHK({scl_w, sda_w}, 2'b11)
        `CHK({scl_o, sda_o}, 2'b00)
    endtask : t_master
    // Switching the unit off in the middle of a START must free both lines at once
    task automatic t_abort();
        wr(4, 8'ha5);
        repeat (28) @(posedge clk);
        wr(4, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        `CHK({scl_w, sda_w}, 2'b11)
        `CHK({scl_oe, sda_oe}, 2'b00)
        rd(4, v);
        `CHK(v, 8'h00)
        `CHK(irq, 1'b0)
    endtask : t_abort

    task automatic close_out();
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        rst_n = 1'b0;
        {wr_en, rd_en, addr, wdata} = '0;
        gie = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_vals();
        t_regs();
        t_master();
        t_abort();
        close_out();
    end
endmodule : tb_tws_regs

`default_nettype wire
